// File: hdl/pfc_pkg.sv
// constants and carrier types for the parallel flash bus controller
// Behaviour
// - read: host holds chip select and output gate low, write strobe high
// - command write: host drives write strobe and chip select low, output gate high
// - in short program mode one word programs with two writes, not four
// - host applies high voltage to accel pin only during accelerated programming
// - after leaving standby, read data is valid only after chip enable access time
// - host restarts an operation aborted by hardware reset; the controller does not restart it, the user reissues the request
// - host reads only after reset to read delay following hardware clear release
`default_nettype none
package pfc_pkg;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int SECT_W = 7;
  localparam int CLK_NS = 10;
  // named delays in ns; counts round up to whole cycles
  localparam int CE_ACCESS_NS  = 90;
  localparam int ADDR_ACC_NS   = 90;
  localparam int WRITE_LOW_NS  = 35;
  localparam int WRITE_HIGH_NS = 30;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_READ_NS  = 50;
  localparam int CE_ACCESS_CYC  = (CE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_ACC_CYC   = (ADDR_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_LOW_CYC  = (WRITE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_READ_CYC  = (RESET_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  // unlock addresses, plus unlock and command codes on the data bus
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_AUTOSEL  = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_ERASE    = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_ER  = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECT_ER  = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_BYPASS   = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_RESET    = 16'h00F0;
  localparam logic [DATA_W-1:0] BYPASS_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] BYPASS_EXIT2 = 16'h0000;
  localparam logic [3:0] SEQ_MAX = 4'h6;

  typedef enum logic [3:0] {
    OP_READ    = 4'h0,
    OP_WRITE   = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_ERASE_SECT = 4'h3,
    OP_ERASE_CHIP = 4'h4,
    OP_AUTOSEL = 4'h5,
    OP_BYPASS_ON  = 4'h6,
    OP_BYPASS_PROG = 4'h7,
    OP_BYPASS_OFF = 4'h8,
    OP_RESET_CMD  = 4'h9,
    OP_HW_RESET   = 4'hA,
    OP_ERASE_MORE = 4'hB
  } pfc_op_type;

  typedef struct packed {
    pfc_op_type        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfc_req_type;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              clear_n;
    logic              accel_hv;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } pfc_pins_type;
endpackage : pfc_pkg
`default_nettype wire

// File: hdl/pfc_seq_rom.sv
// command sequence table: bus cycle k of an operation
`default_nettype none
module pfc_seq_rom
  import pfc_pkg::*;
(
  // selection
  input  wire pfc_op_type        op,
  input  wire logic [3:0]        step,
  input  wire logic [ADDR_W-1:0] user_addr,
  input  wire logic [DATA_W-1:0] user_data,
  // cycle content
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      data,
  output logic [3:0]             count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SECT_W-1:0] sect;
  assign sect = user_addr[ADDR_W-1 -: SECT_W];

  always_comb
  begin
    addr  = UNLOCK_ADDR1;
    data  = UNLOCK_DATA1;
    count = 4'h1;
    if (step == 4'h1)
    begin
      addr = UNLOCK_ADDR2;
      data = UNLOCK_DATA2;
    end
    unique case (op)
      OP_WRITE:
      begin
        addr = user_addr;
        data = user_data;
      end
      OP_PROGRAM:
      begin
        count = 4'h4;
        if (step == 4'h2) data = CMD_PROGRAM;
        if (step == 4'h3)
        begin
          addr = user_addr;
          data = user_data;
        end
      end
      OP_AUTOSEL, OP_BYPASS_ON:
      begin
        count = 4'h3;
        if (step == 4'h2) data = (op == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_BYPASS;
      end
      OP_ERASE_SECT, OP_ERASE_CHIP:
      begin
        count = SEQ_MAX;
        if (step == 4'h2) data = CMD_ERASE;
        if (step == 4'h4)
        begin
          addr = UNLOCK_ADDR2;
          data = UNLOCK_DATA2;
        end
        if (step == 4'h5)
        begin
          addr = (op == OP_ERASE_SECT) ? {sect, {(ADDR_W-SECT_W){1'b0}}} : UNLOCK_ADDR1;
          data = (op == OP_ERASE_SECT) ? CMD_SECT_ER : CMD_CHIP_ER;
        end
      end
      OP_ERASE_MORE:
      begin
        addr = {sect, {(ADDR_W-SECT_W){1'b0}}};
        data = CMD_SECT_ER;
      end
      OP_BYPASS_PROG:
      begin
        count = 4'h2;
        data = (step == 4'h0) ? CMD_PROGRAM : user_data;
        addr = (step == 4'h0) ? user_addr : user_addr;
      end
      OP_BYPASS_OFF:
      begin
        count = 4'h2;
        addr = user_addr;
        data = (step == 4'h0) ? BYPASS_EXIT1 : BYPASS_EXIT2;
      end
      OP_RESET_CMD:
      begin
        addr = user_addr;
        data = CMD_RESET;
      end
      default:
      begin
        addr = user_addr;
        data = user_data;
      end
    endcase
  end
endmodule : pfc_seq_rom
`default_nettype wire

// File: hdl/pfc_ctrl.sv
// host-side bus controller driving the flash strobes, address and data
`default_nettype none
module pfc_ctrl
  import pfc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // user request
  input  wire logic              req_valid,
  input  wire pfc_req_type       req,
  output logic                   req_ready,
  // user answer
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   in_bypass,
  // flash pins
  output logic                   chip_select_n,
  output logic                   output_gate_n,
  output logic                   write_strobe_n,
  output logic                   hardware_clear_n,
  output logic                   accel_pin,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              done_busy_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_RSETUP = 7'b0000010,
    ST_RWAIT = 7'b0000100,
    ST_WLOW  = 7'b0001000,
    ST_WHIGH = 7'b0010000,
    ST_CLR   = 7'b0100000,
    ST_CLRW  = 7'b1000000
  } pfc_state_type;

  typedef struct packed {
    pfc_state_type     st;
    pfc_req_type       cur;
    logic [3:0]        step;
    logic [CNT_W-1:0]  cnt;
    logic              bypass;
    logic              ready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    pfc_pins_type      pins;
  } pfc_regs_type;

  pfc_regs_type r;
  pfc_regs_type next_r;
  logic [ADDR_W-1:0] seq_addr;
  logic [DATA_W-1:0] seq_data;
  logic [3:0]        seq_count;

  pfc_seq_rom u_rom (
    .op        (r.cur.op),
    .step      (r.step),
    .user_addr (r.cur.addr),
    .user_data (r.cur.data),
    .addr      (seq_addr),
    .data      (seq_data),
    .count     (seq_count)
  );

  localparam pfc_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
    clear_n: 1'b1, accel_hv: 1'b0, addr: '0, dq_out: '0, dq_oe: 1'b0};
  // one constant, so the strobes never pass through zero while reset lands
  localparam pfc_regs_type REGS_RESET = '{st: ST_IDLE,
    cur: '{op: OP_READ, addr: '0, data: '0}, step: 4'h0, cnt: '0, bypass: 1'b0,
    ready: 1'b1, rvalid: 1'b0, rdata: '0, pins: PINS_IDLE};

  always_comb
  begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    unique case (r.st)
      ST_IDLE:
      begin
        next_r.pins.ce_n = 1'b1;
        next_r.pins.oe_n = 1'b1;
        next_r.pins.we_n = 1'b1;
        next_r.pins.dq_oe = 1'b0;
        if (req_valid && r.ready)
        begin
          next_r.cur   = req;
          next_r.step  = 4'h0;
          next_r.ready = 1'b0;
          next_r.cnt   = '0;
          // high voltage only around bypass programming
          next_r.pins.accel_hv = (req.op == OP_BYPASS_PROG);
          if (req.op == OP_HW_RESET)
          begin
            next_r.pins.clear_n = 1'b0;
            next_r.st = ST_CLR;
          end
          else if (req.op == OP_READ)
          begin
            next_r.pins.addr = req.addr;
            next_r.pins.ce_n = 1'b0;
            next_r.st = ST_RSETUP;
          end
          else
            next_r.st = ST_WLOW;
        end
      end
      ST_RSETUP:
      begin
        next_r.pins.oe_n = 1'b0;
        next_r.pins.we_n = 1'b1;
        next_r.st = ST_RWAIT;
      end
      ST_RWAIT:
      begin
        next_r.cnt = r.cnt + 1'b1;
        // chip select fell from standby, so wait the longer of both accesses
        if (r.cnt >= CNT_W'(CE_ACCESS_CYC > ADDR_ACC_CYC ? CE_ACCESS_CYC
                                                          : ADDR_ACC_CYC))
        begin
          next_r.rdata  = data_i;
          next_r.rvalid = 1'b1;
          next_r.pins.oe_n = 1'b1;
          next_r.pins.ce_n = 1'b1;
          next_r.ready  = 1'b1;
          next_r.st     = ST_IDLE;
        end
      end
      ST_WLOW:
      begin
        next_r.pins.addr   = seq_addr;
        next_r.pins.dq_out = seq_data;
        next_r.pins.dq_oe  = 1'b1;
        next_r.pins.oe_n   = 1'b1;
        next_r.pins.ce_n   = 1'b0;
        next_r.pins.we_n   = 1'b0;
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= CNT_W'(WRITE_LOW_CYC))
        begin
          next_r.pins.we_n = 1'b1;
          next_r.cnt = '0;
          next_r.st  = ST_WHIGH;
        end
      end
      ST_WHIGH:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= CNT_W'(WRITE_HIGH_CYC))
        begin
          next_r.cnt  = '0;
          next_r.step = r.step + 4'h1;
          if (r.step + 4'h1 >= seq_count)
          begin
            // deselect now; device finishes any program or erase itself
            next_r.pins.ce_n  = 1'b1;
            next_r.pins.dq_oe = 1'b0;
            next_r.pins.accel_hv = 1'b0;
            if (r.cur.op == OP_BYPASS_ON) next_r.bypass = 1'b1;
            if (r.cur.op == OP_BYPASS_OFF || r.cur.op == OP_RESET_CMD) next_r.bypass = 1'b0;
            next_r.ready = 1'b1;
            next_r.st = ST_IDLE;
          end
          else
            next_r.st = ST_WLOW;
        end
      end
      ST_CLR:
      begin
        next_r.pins.ce_n  = 1'b1;
        next_r.pins.oe_n  = 1'b1;
        next_r.pins.we_n  = 1'b1;
        next_r.pins.dq_oe = 1'b0;
        next_r.pins.accel_hv = 1'b0;
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= CNT_W'(RESET_PULSE_CYC))
        begin
          next_r.pins.clear_n = 1'b1;
          next_r.cnt = '0;
          next_r.bypass = 1'b0;
          next_r.st = ST_CLRW;
        end
      end
      ST_CLRW:
      begin
        if (r.cnt < CNT_W'(RESET_READ_CYC))
          next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= CNT_W'(RESET_READ_CYC) && done_busy_flag)
        begin
          next_r.ready = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= REGS_RESET;
    end
    else
      r <= next_r;
  end

  assign req_ready        = r.ready;
  assign rd_valid         = r.rvalid;
  assign rd_data          = r.rdata;
  assign in_bypass        = r.bypass;
  assign chip_select_n    = r.pins.ce_n;
  assign output_gate_n    = r.pins.oe_n;
  assign write_strobe_n   = r.pins.we_n;
  assign hardware_clear_n = r.pins.clear_n;
  assign accel_pin        = r.pins.accel_hv;
  assign addr_out         = r.pins.addr;
  assign data_o           = r.pins.dq_out;
  assign data_oe          = r.pins.dq_oe;
endmodule : pfc_ctrl
`default_nettype wire

// File: verification/pfc_ctrl_chk.sv
// concurrent checks on the flash bus controller ports
`default_nettype none
module pfc_ctrl_chk
  import pfc_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // user side
  input wire logic              req_valid,
  input wire pfc_req_type       req,
  input wire logic              req_ready,
  input wire logic              rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              in_bypass,
  // flash side
  input wire logic              chip_select_n,
  input wire logic              output_gate_n,
  input wire logic              write_strobe_n,
  input wire logic              hardware_clear_n,
  input wire logic              accel_pin,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              data_oe,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic              done_busy_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  pfc_op_type       cur_op;
  logic [3:0]       wr_n;
  logic [CNT_W-1:0] low_n;
  logic [CNT_W-1:0] cs_n;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_op <= OP_READ;
      wr_n   <= 4'h0;
      low_n  <= 8'h00;
      cs_n   <= 8'h00;
    end
    else
    begin
      if (req_valid && req_ready)
      begin
        cur_op <= req.op;
        wr_n   <= 4'h0;
      end
      else if ($fell(write_strobe_n))
        wr_n <= wr_n + 4'h1;
      low_n <= hardware_clear_n ? 8'h00 : low_n + 8'h01;
      cs_n  <= chip_select_n ? 8'h00 : cs_n + 8'h01;
    end
  end
  chk_read_strobes: assert property (!output_gate_n |-> write_strobe_n && !chip_select_n)
    else $error("read with bad strobes");
  chk_write_strobes: assert property (!write_strobe_n |-> output_gate_n && !chip_select_n
    && data_oe) else $error("write with bad strobes");
  chk_read_latency: assert property (req_valid && req_ready && req.op == OP_READ
    |-> ##[12:13] rd_valid) else $error("read answer late");
  chk_access_time: assert property (rd_valid |-> cs_n >= CE_ACCESS_CYC)
    else $error("read data taken early");
  chk_pulse_width: assert property ($rose(hardware_clear_n) |-> low_n >= RESET_PULSE_CYC)
    else $error("reset pulse short");
  chk_reset_read: assert property ($rose(hardware_clear_n) |-> output_gate_n [*5])
    else $error("read too soon after reset");
  chk_reset_quiet: assert property (!hardware_clear_n |-> output_gate_n && write_strobe_n)
    else $error("access during reset");
  chk_accel_only: assert property (accel_pin |-> in_bypass && output_gate_n)
    else $error("high voltage outside programming");
  chk_accel_drive: assert property (cur_op == OP_BYPASS_PROG && !write_strobe_n |-> accel_pin)
    else $error("high voltage missing in short program");
  chk_prog_writes: assert property ($rose(req_ready) && cur_op == OP_PROGRAM |-> wr_n == 4'h4)
    else $error("program write count");
  chk_bypass_writes: assert property ($rose(req_ready) && cur_op == OP_BYPASS_PROG
    |-> wr_n == 4'h2) else $error("short program write count");
  cover property (req_valid && req_ready && req.op == OP_BYPASS_PROG);
  cover property ($rose(hardware_clear_n));
  cover property (rd_valid);
endmodule // pfc_ctrl_chk
bind pfc_ctrl pfc_ctrl_chk pfc_ctrl_chk_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
  .in_bypass(in_bypass), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
  .write_strobe_n(write_strobe_n), .hardware_clear_n(hardware_clear_n),
  .accel_pin(accel_pin), .addr_out(addr_out), .data_o(data_o), .data_oe(data_oe),
  .data_i(data_i), .done_busy_flag(done_busy_flag));
`default_nettype wire

// File: verification/pfc_flash_model.sv
// behavioural flash device seen from the controller pins
`default_nettype none
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter logic [7:0] ID_CODE  = 8'h3C, // arbitrary value
  parameter int         BUSY_CYC = 40,
  parameter int         REC_CYC  = 6
)(
  // clock for timers and for latching the last driven read word
  input  wire logic              clk,
  // pins
  input  wire logic              chip_select_n,
  input  wire logic              output_gate_n,
  input  wire logic              write_strobe_n,
  input  wire logic              hardware_clear_n,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic [DATA_W-1:0] data_o,
  output logic [DATA_W-1:0]      data_i,
  output logic                   done_busy_flag,
  // observation
  output int                     wr_cnt,
  output logic [ADDR_W-1:0]      last_a,
  output logic [DATA_W-1:0]      last_d
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] prev;
  logic              auto;
  logic              drv;
  int                tmr;
  int                rec;
  int                ce_t;
  initial
  begin
    auto = 1'b0;
    tmr = 0;
    rec = 0;
    ce_t = 0;
    wr_cnt = 0;
    q = 16'h0000;
    prev = 16'h0000;
  end
  assign word = auto ? {8'h00, ID_CODE} : (addr_out[15:0] ^ 16'h5A5A);
  // no pull on the bus: released lines show the inverse of the last word
  assign drv = hardware_clear_n && !chip_select_n && !output_gate_n
    && ce_t >= CE_ACCESS_CYC;
  assign data_i = drv ? word : ~q;
  assign done_busy_flag = (tmr == 0) && (rec == 0);
  always @(posedge write_strobe_n)
    if (!chip_select_n && hardware_clear_n && output_gate_n)
    begin
      wr_cnt = wr_cnt + 1;
      last_a = addr_out;
      last_d = data_o;
      if (prev == CMD_PROGRAM)
        tmr <= BUSY_CYC;
      if (data_o == CMD_AUTOSEL)
        auto = 1'b1;
      else if (data_o == CMD_RESET || data_o == BYPASS_EXIT2)
        auto = 1'b0;
      prev = data_o;
    end
  always @(posedge clk)
  begin
    ce_t <= chip_select_n ? 0 : ce_t + 1;
    if (drv)
      q <= word;
    if (!hardware_clear_n)
    begin
      if (tmr > 0)
        rec <= REC_CYC;
      tmr <= 0;
      auto = 1'b0;
      prev = 16'h0000;
    end
    else if (rec > 0)
      rec <= rec - 1;
    else if (tmr > 0)
      tmr <= tmr - 1;
  end
endmodule // pfc_flash_model
`default_nettype wire

// File: verification/test_pfc_ctrl.sv
// self-checking bench for the flash bus controller
`default_nettype none
module test_pfc_ctrl
  import pfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  logic clk, rst, req_valid, req_ready, rd_valid, in_bypass, busy_seen;
  logic cs_n, oe_n, we_n, clr_n, acc, d_oe, rdy;
  pfc_req_type       req;
  logic [ADDR_W-1:0] a, last_a;
  logic [DATA_W-1:0] rd_data, d_o, d_i, got, last_d;
  int wr_cnt, num_errors, total_checks;
  pfc_ctrl pfc_ctrl_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .in_bypass(in_bypass),
    .chip_select_n(cs_n), .output_gate_n(oe_n), .write_strobe_n(we_n),
    .hardware_clear_n(clr_n), .accel_pin(acc), .addr_out(a), .data_o(d_o),
    .data_oe(d_oe), .data_i(d_i), .done_busy_flag(rdy));
  pfc_flash_model #(.ID_CODE(ID)) pfc_flash_model_inst (.clk(clk), .chip_select_n(cs_n),
    .output_gate_n(oe_n), .write_strobe_n(we_n), .hardware_clear_n(clr_n), .addr_out(a),
    .data_o(d_o), .data_i(d_i), .done_busy_flag(rdy), .wr_cnt(wr_cnt),
    .last_a(last_a), .last_d(last_d));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (!clr_n && !rdy)
      busy_seen <= 1'b1;
  task finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task check_flag(input logic g, input logic e);
    check_word({31'h0, g}, {31'h0, e});
  endtask
  // entered and left just after a rising edge
  task run(input pfc_op_type op, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{op, ad, dt};
    while (!req_ready && n < 3000)
    begin
      @(posedge clk) #1;
      n++;
    end
    @(posedge clk) #1;
    req_valid = 1'b0;
    while (!req_ready && n < 3000)
    begin
      @(posedge clk) #1;
      n++;
      if (rd_valid)
        got = rd_data;
    end
    if (n >= 3000)
      num_errors++;
  endtask
  task wr(input pfc_op_type op, input logic [21:0] ad, input logic [15:0] dt, input int n,
    input logic [15:0] ed);
    int c0;
    c0 = wr_cnt;
    run(op, ad, dt);
    check_word(wr_cnt - c0, n);
    check_word(last_d, ed);
  endtask
  task rd(input logic [21:0] ad, input logic [15:0] ed);
    got = 16'hFFFF;
    run(OP_READ, ad, 16'h0000);
    check_word(got, ed);
  endtask
  task t_read();
    rd(22'h012345, 16'h2345 ^ 16'h5A5A);
    rd(22'h3FFFFF, 16'hFFFF ^ 16'h5A5A);
  endtask
  task t_program();
    wr(OP_PROGRAM, 22'h2ABCDE, 16'h1234, 4, 16'h1234);
    check_word(last_a, 22'h2ABCDE);
    wr(OP_WRITE, 22'h000555, CMD_RESET, 1, CMD_RESET);
  endtask
  task t_bypass();
    wr(OP_BYPASS_ON, 22'h0, 16'h0, 3, CMD_BYPASS);
    check_flag(in_bypass, 1'b1);
    wr(OP_BYPASS_PROG, 22'h00F00F, 16'hBEEF, 2, 16'hBEEF);
    check_word(last_a, 22'h00F00F);
    wr(OP_BYPASS_OFF, 22'h0, 16'h0, 2, BYPASS_EXIT2);
    check_flag(in_bypass, 1'b0);
  endtask
  task t_erase();
    wr(OP_ERASE_SECT, 22'h3F8000, 16'h0, 6, CMD_SECT_ER);
    check_word(last_a[21:15], 7'h7F);
    wr(OP_ERASE_MORE, 22'h008000, 16'h0, 1, CMD_SECT_ER);
    check_word(last_a[21:15], 7'h01);
    wr(OP_ERASE_CHIP, 22'h0, 16'h0, 6, CMD_CHIP_ER);
  endtask
  task t_auto();
    wr(OP_AUTOSEL, 22'h0, 16'h0, 3, CMD_AUTOSEL);
    rd(22'h000001, {8'h00, ID});
    wr(OP_RESET_CMD, 22'h0, 16'h0, 1, CMD_RESET);
    rd(22'h000010, 16'h0010 ^ 16'h5A5A);
  endtask
  task t_hwrst();
    wr(OP_AUTOSEL, 22'h0, 16'h0, 3, CMD_AUTOSEL);
    wr(OP_PROGRAM, 22'h000100, 16'hA5A5, 4, 16'hA5A5);
    busy_seen = 1'b0;
    run(OP_HW_RESET, 22'h0, 16'h0);
    check_flag(busy_seen, 1'b1);
    check_flag(rdy, 1'b1);
    rd(22'h000200, 16'h0200 ^ 16'h5A5A);
    wr(OP_PROGRAM, 22'h000100, 16'hA5A5, 4, 16'hA5A5);
    // let the restarted program finish so this reset meets an idle device
    while (!rdy)
      @(posedge clk) #1;
    busy_seen = 1'b0;
    run(OP_HW_RESET, 22'h0, 16'h0);
    check_flag(busy_seen, 1'b0);
    check_flag(rdy, 1'b1);
  endtask
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    busy_seen = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_read();
    t_program();
    t_bypass();
    t_erase();
    t_auto();
    t_hwrst();
    finish_test();
  end
  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule // test_pfc_ctrl
`default_nettype wire
